// ---- include/pbs_pkg.sv ----
// shared constants and types for the pipelined burst memory command block
package pbs_pkg;

   // ----------------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int BURST_W = 2;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = ADDR_W + LANES + DATA_W;

   // ----------------------------------------------------------------------
   // asynchronous input synchroniser layout and reset values
   // ----------------------------------------------------------------------
   localparam int SYNC_W = 3;
   localparam int SYNC_OE = 0;
   localparam int SYNC_ORDER = 1;
   localparam int SYNC_SNOOZE = 2;
   // output enable inactive, interleaved order, snooze off
   localparam logic [SYNC_W-1:0] SYNC_RST = 3'h3;

   // ----------------------------------------------------------------------
   // reset values and counter constants
   // ----------------------------------------------------------------------
   localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h0_0000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
   localparam logic [LANES-1:0] MASK_ZERO = 4'h0;

   // ----------------------------------------------------------------------
   // burst type chosen by the last load cycle
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      BST_IDLE  = 3'h1,
      BST_READ  = 3'h2,
      BST_WRITE = 3'h4
   } pbs_burst_t;

   // ----------------------------------------------------------------------
   // operation travelling down the two-stage pipeline
   // ----------------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NONE  = 5'h01,
      OP_READ  = 5'h02,
      OP_DUMMY = 5'h04,
      OP_WRITE = 5'h08,
      OP_ABORT = 5'h10
   } pbs_op_t;

endpackage

// ---- include/pbs_stream_if.sv ----
// valid/ready word stream between the command block and its write buffer
`timescale 1ns/10ps
interface pbs_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/pbs_fifo.sv ----
// flip-flop write buffer with registered full and empty flags
`timescale 1ns/10ps
module pbs_fifo
   import pbs_pkg::*;
#(
   parameter int W = FIFO_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic ref_clk,
   input wire logic reset,
   pbs_stream_if.snk fill,
   pbs_stream_if.src drain
);

   // depth must be a power of two so the pointers wrap by themselves
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);
   localparam logic [PW:0] CNT_ZERO = (PW+1)'(0);
   localparam logic [PW-1:0] PTR_ZERO = PW'(0);

   logic [W-1:0] store_r [DEPTH];
   logic [W-1:0] store_nxt [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] wr_ptr_nxt;
   logic [PW-1:0] rd_ptr_r;
   logic [PW-1:0] rd_ptr_nxt;
   logic [PW:0] count_r;
   logic [PW:0] count_nxt;
   logic ready_r;
   logic ready_nxt;
   logic valid_r;
   logic valid_nxt;
   logic push;
   logic pop;

   // ----------------------------------------------------------------------
   // next state: flags are registered so neither side sees a comb path
   // ----------------------------------------------------------------------
   always_comb
   begin
      push = fill.valid && ready_r;
      pop = valid_r && drain.ready;
      store_nxt = store_r;
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt = count_r;
      if (push)
      begin
         store_nxt[wr_ptr_r] = fill.data;
         wr_ptr_nxt = wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
         rd_ptr_nxt = rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
         count_nxt = count_r + 1'b1;
      end
      else if (pop && !push)
      begin
         count_nxt = count_r - 1'b1;
      end
      ready_nxt = (count_nxt != CNT_FULL);
      valid_nxt = (count_nxt != CNT_ZERO);
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            store_r[i] <= '0;
         end
         wr_ptr_r <= PTR_ZERO;
         rd_ptr_r <= PTR_ZERO;
         count_r <= CNT_ZERO;
         ready_r <= 1'b1;
         valid_r <= 1'b0;
      end
      else
      begin
         store_r <= store_nxt;
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         ready_r <= ready_nxt;
         valid_r <= valid_nxt;
      end
   end

   assign fill.ready = ready_r;
   assign drain.valid = valid_r;
   assign drain.data = store_r[rd_ptr_r];

endmodule // pbs_fifo

// ---- rtl/pbs_burst_sram_if.sv ----
// command decode and data pipeline of a pipelined no-turnaround burst memory
// Summary of operation
// - deselect on inactive select; continue-deselect follows deselect
// - selected load with read begins read burst
// - continue cycles repeat the burst's chosen type
// - two-bit counter steps each read or write continue, wraps at four
// - read with output enable high is dummy
// - selected load with write and enables begins write
// - all byte enables high means write abort
// - each byte enable gates only its lane
// - drivers turned off during writes automatically
// - clock enable high freezes state and address
// - inhibit keeps read drive, never writes memory
// - controls sampled on rising edge except async pins
// - data pins undriven from power-up until a read
// - load samples selects; advance ignores them, counts in a read or write burst
// - order select high interleaved, low linear
// - snooze ignores inputs, floats outputs, keeps data
`timescale 1ns/10ps
module pbs_burst_sram_if
   import pbs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clock_gate_enable_n,
   input wire logic chip_select_low_first,
   input wire logic chip_select_high_second,
   input wire logic chip_select_low_third,
   input wire logic advance_or_load,
   input wire logic read_write_select,
   input wire logic [LANES-1:0] byte_write_enables,
   input wire logic output_enable_n,
   input wire logic burst_order_select,
   input wire logic snooze_input,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   output logic mem_rd_en,
   output logic [ADDR_W-1:0] mem_rd_addr,
   input wire logic [DATA_W-1:0] mem_rd_data,
   output logic mem_wr_en,
   output logic [ADDR_W-1:0] mem_wr_addr,
   output logic [LANES-1:0] mem_wr_mask,
   output logic [DATA_W-1:0] mem_wr_data,
   input wire logic mem_wr_ready,
   output logic write_buffer_ready
);

   // ----------------------------------------------------------------------
   // burst address step: xor for interleaved order, add for linear
   // ----------------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] burst_addr(
      input logic [ADDR_W-1:0] base,
      input logic [BURST_W-1:0] cnt,
      input logic interleave
   );
      logic [BURST_W-1:0] low;
      low = interleave ? (base[BURST_W-1:0] ^ cnt) : (base[BURST_W-1:0] + cnt);
      return {base[ADDR_W-1:BURST_W], low};
   endfunction

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   logic [SYNC_W-1:0] sync3_r;
   logic [SYNC_W-1:0] filt_r;
   logic [SYNC_W-1:0] filt_nxt;
   logic oe_high;
   logic interleave;
   logic snooze;
   logic advance;
   logic selected;
   logic any_lane;

   pbs_burst_t burst_r;
   pbs_burst_t burst_nxt;
   logic [ADDR_W-1:0] base_r;
   logic [ADDR_W-1:0] base_nxt;
   logic [BURST_W-1:0] count_r;
   logic [BURST_W-1:0] count_nxt;
   pbs_op_t kind;
   logic [ADDR_W-1:0] op_addr;

   pbs_op_t s1_kind_r;
   pbs_op_t s1_kind_nxt;
   logic [ADDR_W-1:0] s1_addr_r;
   logic [ADDR_W-1:0] s1_addr_nxt;
   logic [LANES-1:0] s1_mask_r;
   logic [LANES-1:0] s1_mask_nxt;
   pbs_op_t s2_kind_r;
   pbs_op_t s2_kind_nxt;
   logic [ADDR_W-1:0] s2_addr_r;
   logic [ADDR_W-1:0] s2_addr_nxt;
   logic [LANES-1:0] s2_mask_r;
   logic [LANES-1:0] s2_mask_nxt;

   logic mem_rd_en_r;
   logic mem_rd_en_nxt;
   logic [ADDR_W-1:0] mem_rd_addr_r;
   logic [ADDR_W-1:0] mem_rd_addr_nxt;
   logic [DATA_W-1:0] dout_r;
   logic [DATA_W-1:0] dout_nxt;
   logic read_phase_r;
   logic read_phase_nxt;
   logic data_oe_r;
   logic data_oe_nxt;

   logic mem_wr_en_r;
   logic mem_wr_en_nxt;
   logic [ADDR_W-1:0] mem_wr_addr_r;
   logic [ADDR_W-1:0] mem_wr_addr_nxt;
   logic [LANES-1:0] mem_wr_mask_r;
   logic [LANES-1:0] mem_wr_mask_nxt;
   logic [DATA_W-1:0] mem_wr_data_r;
   logic [DATA_W-1:0] mem_wr_data_nxt;

   pbs_stream_if #(.W(FIFO_W)) fill_if ();
   pbs_stream_if #(.W(FIFO_W)) drain_if ();

   // ----------------------------------------------------------------------
   // asynchronous pins: four flops, a change counts when stages 2 and 3 agree
   // ----------------------------------------------------------------------
   always_comb
   begin
      filt_nxt = filt_r;
      for (int i = 0; i < SYNC_W; i++)
      begin
         if (sync2_r[i] == sync3_r[i])
         begin
            filt_nxt[i] = sync3_r[i];
         end
      end
   end

   // synchronisers keep running while the clock is gated so snooze exit is seen
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
         sync3_r <= SYNC_RST;
         filt_r <= SYNC_RST;
      end
      else
      begin
         sync1_r <= {snooze_input, burst_order_select, output_enable_n};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         filt_r <= filt_nxt;
      end
   end

   assign oe_high = filt_r[SYNC_OE];
   assign interleave = filt_r[SYNC_ORDER];
   assign snooze = filt_r[SYNC_SNOOZE];
   // a gated or snoozing edge changes nothing in the pipeline
   assign advance = !clock_gate_enable_n && !snooze;
   assign selected = !chip_select_low_first && chip_select_high_second && !chip_select_low_third;
   assign any_lane = !(&byte_write_enables);

   // ----------------------------------------------------------------------
   // command decode, burst counter and pipeline next values
   // ----------------------------------------------------------------------
   always_comb
   begin
      burst_nxt = burst_r;
      base_nxt = base_r;
      count_nxt = count_r;
      kind = OP_NONE;
      op_addr = base_r;
      s1_kind_nxt = s1_kind_r;
      s1_addr_nxt = s1_addr_r;
      s1_mask_nxt = s1_mask_r;
      s2_kind_nxt = s2_kind_r;
      s2_addr_nxt = s2_addr_r;
      s2_mask_nxt = s2_mask_r;
      mem_rd_en_nxt = 1'b0;
      mem_rd_addr_nxt = mem_rd_addr_r;
      dout_nxt = dout_r;
      read_phase_nxt = read_phase_r;
      if (advance)
      begin
         if (!advance_or_load)
         begin
            // load: selects and direction are only looked at here
            count_nxt = BURST_ZERO;
            base_nxt = address;
            op_addr = address;
            if (!selected)
            begin
               burst_nxt = BST_IDLE;
            end
            else if (read_write_select)
            begin
               burst_nxt = BST_READ;
               kind = oe_high ? OP_DUMMY : OP_READ;
            end
            else
            begin
               burst_nxt = BST_WRITE;
               kind = any_lane ? OP_WRITE : OP_ABORT;
            end
         end
         else
         begin
            // continue: the type comes from the burst, not from the pins
            case (burst_r)
               BST_READ:
               begin
                  count_nxt = count_r + BURST_STEP;
                  kind = oe_high ? OP_DUMMY : OP_READ;
               end
               BST_WRITE:
               begin
                  count_nxt = count_r + BURST_STEP;
                  kind = any_lane ? OP_WRITE : OP_ABORT;
               end
               default:
               begin
                  kind = OP_NONE;
               end
            endcase
            op_addr = burst_addr(base_r, count_nxt, interleave);
         end
         s1_kind_nxt = kind;
         s1_addr_nxt = op_addr;
         s1_mask_nxt = ~byte_write_enables;
         s2_kind_nxt = s1_kind_r;
         s2_addr_nxt = s1_addr_r;
         s2_mask_nxt = s1_mask_r;
         // dummy reads and aborts never reach the memory
         mem_rd_en_nxt = (kind == OP_READ);
         mem_rd_addr_nxt = op_addr;
         if (s1_kind_r == OP_READ)
         begin
            dout_nxt = mem_rd_data;
         end
         read_phase_nxt = (s1_kind_r == OP_READ);
      end
   end

   // ----------------------------------------------------------------------
   // output drive: reevaluated every edge, even while gated
   // ----------------------------------------------------------------------
   always_comb
   begin
      data_oe_nxt = read_phase_nxt && !oe_high && !snooze;
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         burst_r <= BST_IDLE;
         base_r <= ADDR_ZERO;
         count_r <= BURST_ZERO;
         s1_kind_r <= OP_NONE;
         s1_addr_r <= ADDR_ZERO;
         s1_mask_r <= MASK_ZERO;
         s2_kind_r <= OP_NONE;
         s2_addr_r <= ADDR_ZERO;
         s2_mask_r <= MASK_ZERO;
         mem_rd_en_r <= 1'b0;
         mem_rd_addr_r <= ADDR_ZERO;
         dout_r <= DATA_ZERO;
         read_phase_r <= 1'b0;
         data_oe_r <= 1'b0;
      end
      else
      begin
         burst_r <= burst_nxt;
         base_r <= base_nxt;
         count_r <= count_nxt;
         s1_kind_r <= s1_kind_nxt;
         s1_addr_r <= s1_addr_nxt;
         s1_mask_r <= s1_mask_nxt;
         s2_kind_r <= s2_kind_nxt;
         s2_addr_r <= s2_addr_nxt;
         s2_mask_r <= s2_mask_nxt;
         mem_rd_en_r <= mem_rd_en_nxt;
         mem_rd_addr_r <= mem_rd_addr_nxt;
         dout_r <= dout_nxt;
         read_phase_r <= read_phase_nxt;
         data_oe_r <= data_oe_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // write capture: data pins taken on the second enabled edge
   // ----------------------------------------------------------------------
   // a gated edge pushes nothing, so an inhibit cycle never writes
   assign fill_if.valid = advance && (s2_kind_r == OP_WRITE);
   assign fill_if.data = {s2_addr_r, s2_mask_r, data_in};

   // buffer decouples pin timing from a memory that may stall
   pbs_fifo #(
      .W(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_write_buffer (
      .ref_clk(ref_clk),
      .reset(reset),
      .fill(fill_if.snk),
      .drain(drain_if.src)
   );

   // ----------------------------------------------------------------------
   // memory write port: one register slice after the buffer
   // ----------------------------------------------------------------------
   assign drain_if.ready = !mem_wr_en_r || mem_wr_ready;

   always_comb
   begin
      mem_wr_en_nxt = mem_wr_en_r;
      mem_wr_addr_nxt = mem_wr_addr_r;
      mem_wr_mask_nxt = mem_wr_mask_r;
      mem_wr_data_nxt = mem_wr_data_r;
      if (drain_if.valid && drain_if.ready)
      begin
         mem_wr_en_nxt = 1'b1;
         {mem_wr_addr_nxt, mem_wr_mask_nxt, mem_wr_data_nxt} = drain_if.data;
      end
      else if (mem_wr_ready)
      begin
         mem_wr_en_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         mem_wr_en_r <= 1'b0;
         mem_wr_addr_r <= ADDR_ZERO;
         mem_wr_mask_r <= MASK_ZERO;
         mem_wr_data_r <= DATA_ZERO;
      end
      else
      begin
         mem_wr_en_r <= mem_wr_en_nxt;
         mem_wr_addr_r <= mem_wr_addr_nxt;
         mem_wr_mask_r <= mem_wr_mask_nxt;
         mem_wr_data_r <= mem_wr_data_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign data_out = dout_r;
   assign data_oe = data_oe_r;
   assign mem_rd_en = mem_rd_en_r;
   assign mem_rd_addr = mem_rd_addr_r;
   assign mem_wr_en = mem_wr_en_r;
   assign mem_wr_addr = mem_wr_addr_r;
   assign mem_wr_mask = mem_wr_mask_r;
   assign mem_wr_data = mem_wr_data_r;
   assign write_buffer_ready = fill_if.ready; // flop inside the buffer

endmodule // pbs_burst_sram_if

// ---- dv/pbs_burst_sram_if_assertions.sv ----
// port checker for the burst memory command block, bound to its top module
`timescale 1ns/10ps
module pbs_port_chk
   import pbs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clock_gate_enable_n,
   input wire logic chip_select_low_first,
   input wire logic chip_select_high_second,
   input wire logic chip_select_low_third,
   input wire logic advance_or_load,
   input wire logic read_write_select,
   input wire logic output_enable_n,
   input wire logic snooze_input,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe,
   input wire logic mem_rd_en,
   input wire logic [ADDR_W-1:0] mem_rd_addr,
   input wire logic [DATA_W-1:0] mem_rd_data
);
   // ----
   // settle counters
   // ----
   logic [2:0] szlo_r, szlo_nxt, szhi_r, szhi_nxt, oelo_r, oelo_nxt, oehi_r, oehi_nxt;
   logic go, sel;

   // saturating run lengths: the async pins pass a four-flop filter, so only long runs are judged
   always_comb
   begin
      szlo_nxt = snooze_input ? 3'h0 : szlo_r + {2'h0, szlo_r != 3'h7};
      szhi_nxt = !snooze_input ? 3'h0 : szhi_r + {2'h0, szhi_r != 3'h7};
      oelo_nxt = output_enable_n ? 3'h0 : oelo_r + {2'h0, oelo_r != 3'h7};
      oehi_nxt = !output_enable_n ? 3'h0 : oehi_r + {2'h0, oehi_r != 3'h7};
   end

   // registers only
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         {szlo_r, szhi_r, oelo_r, oehi_r} <= 12'h000;
      end
      else
      begin
         {szlo_r, szhi_r, oelo_r, oehi_r} <= {szlo_nxt, szhi_nxt, oelo_nxt, oehi_nxt};
      end
   end

   // live edge, and all three selects active
   assign go = !clock_gate_enable_n && !snooze_input && szlo_r == 3'h7;
   assign sel = !chip_select_low_first && chip_select_high_second && !chip_select_low_third;

   // ----
   // properties
   // ----
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence ds_s; go && !advance_or_load && !sel; endsequence
   sequence rd_s; go && !advance_or_load && sel && read_write_select && !output_enable_n && oelo_r == 3'h7; endsequence
   sequence dm_s; go && !advance_or_load && sel && read_write_select && output_enable_n && oehi_r == 3'h7; endsequence
   sequence wr_s; go && !advance_or_load && sel && !read_write_select; endsequence
   sequence rd_lat_s; rd_s ##1 (go && !output_enable_n); endsequence

   oe_off_a: assert property (oehi_r == 3'h7 |-> !data_oe)
      else $error("data pins driven with output enable high");
   snooze_float_a: assert property (szhi_r == 3'h7 |-> !data_oe && !mem_rd_en)
      else $error("activity while snoozing");
   gate_hold_a: assert property (clock_gate_enable_n |=> !mem_rd_en && $stable(data_out))
      else $error("gated edge changed state");
   desel_quiet_a: assert property (ds_s |=> !mem_rd_en)
      else $error("read issued on deselect");
   cont_idle_a: assert property (ds_s ##1 (go && advance_or_load) |=> !mem_rd_en)
      else $error("continue after deselect did something");
   read_issue_a: assert property (rd_s |=> mem_rd_en && mem_rd_addr == $past(address))
      else $error("read load not issued at its address");
   dummy_read_a: assert property (dm_s |=> !mem_rd_en)
      else $error("dummy read reached memory");
   read_data_a: assert property (rd_lat_s |=> data_oe && data_out == $past(mem_rd_data))
      else $error("read data late or wrong");
   write_off_a: assert property (wr_s ##1 go |=> !data_oe)
      else $error("data pins driven in write");
endmodule // pbs_port_chk

bind pbs_burst_sram_if pbs_port_chk u_pbs_port_chk (.ref_clk, .reset, .clock_gate_enable_n,
   .chip_select_low_first, .chip_select_high_second, .chip_select_low_third, .advance_or_load,
   .read_write_select, .output_enable_n, .snooze_input, .address, .data_out, .data_oe, .mem_rd_en,
   .mem_rd_addr, .mem_rd_data);

// ---- dv/pbs_mem_model.sv ----
// memory array model with write back-pressure
`timescale 1ns/10ps
module pbs_mem_model
   import pbs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic stall,
   input wire logic mem_rd_en,
   input wire logic [ADDR_W-1:0] mem_rd_addr,
   output logic [DATA_W-1:0] mem_rd_data,
   input wire logic mem_wr_en,
   input wire logic [ADDR_W-1:0] mem_wr_addr,
   input wire logic [LANES-1:0] mem_wr_mask,
   input wire logic [DATA_W-1:0] mem_wr_data,
   output logic mem_wr_ready
);
   logic [DATA_W-1:0] arr [int];
   logic [DATA_W-1:0] word;

   // read answer lands mid-cycle, before the edge that takes it, and then holds
   always @(negedge ref_clk)
   begin
      if (mem_rd_en === 1'b1)
      begin
         mem_rd_data <= arr.exists(mem_rd_addr) ? arr[mem_rd_addr] : DATA_ZERO;
      end
   end

   // writes land lane by lane; random ready so the buffer sees stalls
   always @(posedge ref_clk)
   begin
      if (mem_wr_en === 1'b1 && mem_wr_ready)
      begin
         word = arr.exists(mem_wr_addr) ? arr[mem_wr_addr] : DATA_ZERO;
         for (int l = 0; l < LANES; l++)
         begin
            if (mem_wr_mask[l]) word[l*LANE_W+:LANE_W] = mem_wr_data[l*LANE_W+:LANE_W];
         end
         arr[mem_wr_addr] = word;
      end
      mem_wr_ready <= !stall && ($urandom % 4 != 0);
   end
endmodule // pbs_mem_model

// ---- dv/pbs_burst_sram_if_tb.sv ----
// self-checking bench for the burst memory command block
`timescale 1ns/10ps
module pbs_burst_sram_if_tb
   import pbs_pkg::*;
;
   logic ref_clk = 1'b0, reset = 1'b1, clock_gate_enable_n = 1'b0, chip_select_low_first = 1'b1;
   logic chip_select_high_second = 1'b0, chip_select_low_third = 1'b1, advance_or_load = 1'b0;
   logic read_write_select = 1'b0, output_enable_n = 1'b1, burst_order_select = 1'b1, snooze_input = 1'b0;
   logic [LANES-1:0] byte_write_enables = 4'hf, mem_wr_mask;
   logic [ADDR_W-1:0] address = 20'h0_0000, mem_rd_addr, mem_wr_addr;
   logic [DATA_W-1:0] data_in = 32'h0000_0000, data_out, mem_rd_data, mem_wr_data, wdat;
   logic data_oe, mem_rd_en, mem_wr_en, mem_wr_ready, write_buffer_ready, stall = 1'b0;
   logic [3:0] s1m, s2m;
   logic [31:0] mdl [int];
   int n_mismatch = 0, checked = 0, il = 1, oe_hi = 1, sz_pin = 0, sz_on = 0, seen_full = 0;
   int bst = 0, base = 0, cnt = 0, s1op = 0, s1a = 0, s2op = 0, s2a = 0;

   initial forever #2.5 ref_clk = ~ref_clk;

   pbs_burst_sram_if u_pbs_burst_sram_if (.*);
   pbs_mem_model u_pbs_mem_model (.*);

   // ----
   // reference model and helpers
   // ----
   function automatic logic [31:0] rd(input int a);
      return mdl.exists(a) ? mdl[a] : 32'h0000_0000;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one controller cycle: k 0 deselect, 1 read load, 2 write load, 3 continue; model steps on live edges
   task automatic cmd(input int k, input int a, input logic [3:0] bw, input logic gate);
      logic en;
      logic wbr;
      logic [2:0] cs;
      @(negedge ref_clk);
      clock_gate_enable_n = gate;
      output_enable_n = 1'(oe_hi);
      burst_order_select = 1'(il);
      snooze_input = 1'(sz_pin);
      advance_or_load = (k == 3);
      cs = k == 3 ? 3'($urandom) : k != 0 ? 3'h2 : a % 3 == 0 ? 3'h6 : a % 3 == 1 ? 3'h0 : 3'h3;
      {chip_select_low_first, chip_select_high_second, chip_select_low_third} = cs;
      read_write_select = k == 3 ? 1'($urandom) : (k == 1);
      byte_write_enables = bw;
      address = k == 3 ? 20'($urandom) : 20'(a);
      data_in = s2op == 3 ? wdat : $urandom;
      wbr = write_buffer_ready;
      if (wbr === 1'b0) seen_full = 1;
      @(posedge ref_clk);
      en = !gate && !sz_on;
      if (en)
      begin
         if (s2op == 3 && wbr === 1'b1)
         begin
            mdl[s2a] = rd(s2a);
            for (int l = 0; l < 4; l++) if (s2m[l]) mdl[s2a][8*l+:8] = wdat[8*l+:8];
         end
         s2op = s1op;
         s2a = s1a;
         s2m = s1m;
         if (s2op == 3) wdat = $urandom;
         if (k == 0) bst = 0;
         if (k == 1 || k == 2)
         begin
            bst = k;
            base = a;
            cnt = 0;
         end
         if (k == 3 && bst != 0) cnt = (cnt + 1) % 4;
         s1a = il ? base ^ cnt : base - base % 4 + (base + cnt) % 4;
         s1op = bst == 0 ? 0 : bst == 1 ? (oe_hi ? 2 : 1) : (bw == 4'hf ? 4 : 3);
         s1m = ~bw;
      end
      #1;
      chk(32'(mem_rd_en), 32'(en && s1op == 1));
      if (en && s1op == 1) chk(32'(mem_rd_addr), 32'(s1a));
      chk(32'(data_oe), 32'(s2op == 1));
      if (s2op == 1) chk(data_out, rd(s2a));
   endtask

   // load, n continues, and a stray load on a gated edge
   task automatic burst(input int k, input int a, input int n, input logic rnd);
      for (int i = 0; i <= n; i++)
      begin
         if (i == 2) cmd(k, a + 4, 4'h0, 1'b1);
         cmd(i == 0 ? k : 3, a, rnd ? 4'($urandom) : 4'h0, 1'b0);
      end
   endtask

   // idle until the memory write port has been quiet for a while; bounded
   task automatic drain();
      int q;
      q = 0;
      for (int i = 0; i < 500 && q < 6; i++)
      begin
         cmd(0, i, 4'hf, 1'b0);
         q = mem_wr_en === 1'b0 ? q + 1 : 0;
      end
      if (q < 6)
      begin
         chk(32'(q), 32'h6);
         summarize();
      end
   endtask

   // ----
   // main sequence
   // ----
   initial
   begin
      int a;
      int b;
      void'($urandom(32'hb7a238aa));
      repeat (16)
      begin
         @(negedge ref_clk);
         chk(32'({data_oe, mem_rd_en, mem_wr_en}), 32'h0);
      end
      reset = 1'b0;
      oe_hi = 0;
      repeat (8) cmd(0, 0, 4'hf, 1'b0);
      $display("test reset done");
      for (int o = 1; o >= 0; o--)
      begin
         il = o;
         repeat (8) cmd(0, 1, 4'hf, 1'b0);
         for (int j = 0; j < 3; j++)
         begin
            a = $urandom % 32'h0001_0000;
            b = a + 32'h0001_0000;
            burst(2, a, 3, 1'b1);
            cmd(0, j, 4'hf, 1'b0);
            cmd(3, a, 4'hf, 1'b0);
            drain();
            burst(1, a, 5, 1'b0);
            burst(2, b, 3, 1'b1);
            drain();
            burst(1, b, 3, 1'b0);
         end
         $display("test bursts order %0d done", o);
      end
      oe_hi = 1;
      repeat (8) cmd(0, 2, 4'hf, 1'b0);
      burst(1, a, 3, 1'b0);
      oe_hi = 0;
      repeat (8) cmd(0, 2, 4'hf, 1'b0);
      $display("test dummy read done");
      sz_pin = 1;
      repeat (8) cmd(0, 0, 4'hf, 1'b0);
      sz_on = 1;
      burst(1, b, 3, 1'b0);
      burst(2, b, 3, 1'b0);
      sz_pin = 0;
      sz_on = 0;
      repeat (8) cmd(0, 0, 4'hf, 1'b0);
      burst(1, b, 3, 1'b0);
      $display("test snooze done");
      seen_full = 0;
      stall = 1'b1;
      for (int j = 0; j < 5; j++) burst(2, 32'h0008_0000 + 16 * j, 3, 1'b0);
      stall = 1'b0;
      drain();
      chk(32'(seen_full), 32'h1);
      for (int j = 0; j < 5; j++) burst(1, 32'h0008_0000 + 16 * j, 3, 1'b0);
      repeat (2) cmd(0, 0, 4'hf, 1'b0);
      $display("test buffer done");
      summarize();
   end
endmodule // pbs_burst_sram_if_tb
